// ==== pkg/bdm_pkg.sv ====
package bdm_pkg;

  // ------------------------------------------------------------------
  // address geometry
  // ------------------------------------------------------------------
  localparam int ADDR_W     = 9;
  localparam int DATA_W     = 8;
  localparam int MEM_DEPTH  = 512;
  localparam int OFFS_W     = 7;

  // ------------------------------------------------------------------
  // bank offsets of mirrored and special locations
  // ------------------------------------------------------------------
  localparam logic [6:0] OFF_INDIRECT_WINDOW = 7'h00;
  localparam logic [6:0] OFF_PC_LOW          = 7'h02;
  localparam logic [6:0] OFF_STATUS          = 7'h03;
  localparam logic [6:0] OFF_INDIRECT_PTR    = 7'h04;
  localparam logic [6:0] OFF_PC_HIGH_LATCH   = 7'h0a;
  localparam logic [6:0] OFF_INT_CONTROL     = 7'h0b;
  localparam logic [6:0] OFF_FAST_LO         = 7'h70;
  localparam logic [6:0] OFF_SFR_LAST        = 7'h1f;
  localparam logic [6:0] OFF_BANK3_SFR_LAST  = 7'h0b;
  localparam logic [8:0] ADDR_FAST_BASE      = 9'h070;

  // read-only locations (table data high byte)
  localparam logic [8:0] ADDR_RO_TABLE_HIGH  = 9'h094;

  // ------------------------------------------------------------------
  // status field positions and reset values
  // ------------------------------------------------------------------
  localparam int ST_INDIRECT_BANK   = 7;
  localparam int ST_BANK_SEL_HIGH   = 6;
  localparam int ST_BANK_SEL_LOW    = 5;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] ZERO_RST   = 8'h00;
  localparam logic [7:0] WINDOW_SELF_READ = 8'h00;

  // ------------------------------------------------------------------
  // core operation codes
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    BDM_OP_NONE,
    BDM_OP_LOAD_ACC,
    BDM_OP_STORE_ACC,
    BDM_OP_LOAD_IMM
  } bdm_op_e;

endpackage

// ==== pkg/bdm_dec_if.sv ====
`timescale 1ns/10ps
// decoded address travelling from decoder to storage
interface bdm_dec_if;
  logic [8:0] phys_addr;
  logic       is_sfr;
  logic       window_self;
  logic       is_ro;
  modport dec (output phys_addr, output is_sfr, output window_self,
               output is_ro);
  modport mem (input phys_addr, input is_sfr, input window_self,
               input is_ro);
endinterface

// ==== rtl/bdm_decode.sv ====
`timescale 1ns/10ps
module bdm_decode
  import bdm_pkg::*;
(
  // operand and bank context
  input  wire logic [6:0] operand,
  input  wire logic [7:0] status_val,
  input  wire logic [7:0] pointer_val,
  // decoded result
  bdm_dec_if.dec          dec
);

  // ------------------------------------------------------------------
  // address forming
  // ------------------------------------------------------------------
  logic [8:0] direct_addr;
  logic [8:0] indirect_addr;
  logic [8:0] eff;

  // direct bank from the two select bits
  assign direct_addr = {status_val[ST_BANK_SEL_HIGH],
                        status_val[ST_BANK_SEL_LOW], operand}; // RULE10
  // indirect: pointer low byte, bank bit as ninth
  assign indirect_addr = {status_val[ST_INDIRECT_BANK],
                          pointer_val}; // RULE4 RULE11
  // window offset redirects through the pointer
  assign eff = (operand == OFF_INDIRECT_WINDOW) ?
               indirect_addr : direct_addr; // RULE5

  // fold mirrored locations onto one physical home
  function automatic logic [8:0] fold(input logic [8:0] a);
    logic [6:0] o;
    o = a[6:0];
    if (o == OFF_PC_LOW || o == OFF_STATUS || o == OFF_INDIRECT_PTR ||
        o == OFF_PC_HIGH_LATCH || o == OFF_INT_CONTROL ||
        o == OFF_INDIRECT_WINDOW) begin
      fold = {2'b00, o}; // RULE12
    end else if (o >= OFF_FAST_LO) begin
      fold = {2'b00, o}; // RULE13
    end else begin
      fold = a;
    end
  endfunction

  // special-function decode by bank
  function automatic logic sfr_hit(input logic [8:0] a);
    if (a[8:7] == 2'b11) begin
      sfr_hit = (a[6:0] <= OFF_BANK3_SFR_LAST);
    end else begin
      sfr_hit = (a[6:0] <= OFF_SFR_LAST);
    end
  endfunction

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign dec.phys_addr   = fold(eff);
  assign dec.is_sfr      = sfr_hit(eff); // RULE2
  assign dec.window_self = (operand == OFF_INDIRECT_WINDOW) &&
                           (pointer_val[6:0] == OFF_INDIRECT_WINDOW);
  assign dec.is_ro       = (eff == ADDR_RO_TABLE_HIGH); // RULE3

endmodule // bdm_decode

// ==== rtl/bdm_top.sv ====
`timescale 1ns/10ps
// How it works
// RULE1 - 512 bytes in four banks
// RULE2 - sfr ranges decoded, rest general purpose
// RULE3 - read-only locations ignore writes
// RULE4 - indirect address is bank bit plus pointer
// RULE5 - window offset in every bank redirects
// RULE6 - window reading itself returns zero
// RULE7 - window writing itself does nothing
// RULE8 - direct moves between accumulator and memory
// RULE9 - immediate loads accumulator, no memory access
// RULE10 - two select bits choose direct bank
// RULE11 - indirect bank bit picks banks 2-3
// RULE12 - core registers mirrored in all banks
// RULE13 - fast region shared by all banks
module bdm_top
  import bdm_pkg::*;
#(
  parameter int DEPTH = MEM_DEPTH
) (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                rst,
  // instruction from core
  input  wire bdm_pkg::bdm_op_e    op,
  input  wire logic [6:0]          operand,
  input  wire logic [7:0]          immediate,
  // hardware-owned status flag updates from the alu
  input  wire logic                flags_we,
  input  wire logic [4:0]          flags_in,
  // read-only table high byte source
  input  wire logic [7:0]          table_high_in,
  // visible state
  output logic [7:0]               accumulator,
  output logic [7:0]               status,
  output logic [7:0]               indirect_pointer,
  output logic [7:0]               program_counter_low,
  output logic [7:0]               program_counter_high_latch,
  output logic [7:0]               interrupt_control,
  output logic                     sfr_access
);

  // ------------------------------------------------------------------
  // storage and decode
  // ------------------------------------------------------------------
  logic [7:0] mem_reg [DEPTH]; // RULE1
  logic [7:0] acc_reg;
  logic [7:0] status_reg;
  logic [7:0] ptr_reg;
  logic [7:0] pcl_reg;
  logic [7:0] program_counter_high_latch_reg;
  logic [7:0] interrupt_control_reg;
  logic [7:0] rd_data;
  logic       wr_en;
  logic       sfr_reg;

  bdm_dec_if dif ();

  bdm_decode bdm_decode_inst (
    .operand     (operand),
    .status_val  (status_reg),
    .pointer_val (ptr_reg),
    .dec         (dif.dec)
  );

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  always_comb begin
    if (dif.window_self) begin
      rd_data = WINDOW_SELF_READ; // RULE6
    end else begin
      case (dif.phys_addr[6:0])
        OFF_PC_LOW:        rd_data = pcl_reg;
        OFF_STATUS:        rd_data = status_reg;
        OFF_INDIRECT_PTR:  rd_data = ptr_reg;
        OFF_PC_HIGH_LATCH: rd_data = program_counter_high_latch_reg;
        OFF_INT_CONTROL:   rd_data = interrupt_control_reg;
        default:           rd_data = mem_reg[dif.phys_addr];
      endcase
      if (dif.is_ro) begin
        rd_data = table_high_in; // RULE3
      end
    end
  end

  // store only when not the window itself and not read-only
  assign wr_en = (op == BDM_OP_STORE_ACC) && !dif.window_self &&
                 !dif.is_ro; // RULE7 RULE3

  // ------------------------------------------------------------------
  // accumulator
  // ------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acc_reg <= ZERO_RST;
    end else begin
      case (op)
        BDM_OP_LOAD_ACC: acc_reg <= rd_data;   // RULE8
        BDM_OP_LOAD_IMM: acc_reg <= immediate; // RULE9
        default:         acc_reg <= acc_reg;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // mirrored core registers
  // ------------------------------------------------------------------
  function automatic logic hit(input logic [6:0] off);
    hit = wr_en && (dif.phys_addr == {2'b00, off});
  endfunction

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_reg <= STATUS_RST;
    end else if (hit(OFF_STATUS)) begin
      status_reg <= {acc_reg[7:5], status_reg[4:3], acc_reg[2:0]}; // RULE12
    end else if (flags_we) begin
      status_reg <= {status_reg[7:5], flags_in};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ptr_reg    <= ZERO_RST;
      pcl_reg    <= ZERO_RST;
      program_counter_high_latch_reg <= ZERO_RST;
      interrupt_control_reg <= ZERO_RST;
    end else begin
      if (hit(OFF_INDIRECT_PTR)) ptr_reg <= acc_reg;       // RULE12
      if (hit(OFF_PC_LOW)) pcl_reg <= acc_reg;             // RULE12
      if (hit(OFF_PC_HIGH_LATCH)) program_counter_high_latch_reg <= acc_reg;   // RULE12
      if (hit(OFF_INT_CONTROL)) interrupt_control_reg <= acc_reg;     // RULE12
    end
  end

  // ------------------------------------------------------------------
  // general storage, flip-flops by index
  // ------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= ZERO_RST;
      end
    end else if (wr_en) begin
      mem_reg[dif.phys_addr] <= acc_reg; // RULE8 RULE13
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sfr_reg <= 1'b0;
    end else begin
      sfr_reg <= (op == BDM_OP_LOAD_ACC || op == BDM_OP_STORE_ACC) &&
                 dif.is_sfr; // RULE2
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign accumulator                = acc_reg;
  assign status                     = status_reg;
  assign indirect_pointer           = ptr_reg;
  assign program_counter_low        = pcl_reg;
  assign program_counter_high_latch = program_counter_high_latch_reg;
  assign interrupt_control          = interrupt_control_reg;
  assign sfr_access                 = sfr_reg;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_imm_load: assert property (@(posedge clock) disable iff (rst) // RULE9
    op == BDM_OP_LOAD_IMM |=> accumulator == $past(immediate))
    else $error("immediate not loaded");

  a_self_read: assert property (@(posedge clock) disable iff (rst) // RULE6
    (op == BDM_OP_LOAD_ACC && dif.window_self) |=> accumulator == 8'h00)
    else $error("window self read not zero");

  a_self_write: assert property (@(posedge clock) disable iff (rst) // RULE7
    (op == BDM_OP_STORE_ACC && dif.window_self) |=>
      $stable(indirect_pointer) && $stable(status))
    else $error("window self write changed state");

  a_ptr_store: assert property (@(posedge clock) disable iff (rst) // RULE12
    (op == BDM_OP_STORE_ACC && operand == OFF_INDIRECT_PTR) |=>
      indirect_pointer == $past(accumulator))
    else $error("pointer not mirrored");

  a_direct_bank: assert property (@(posedge clock) disable iff (rst) // RULE10
    (operand >= 7'h20 && operand < 7'h70) |->
      dif.phys_addr[8:7] == status[6:5])
    else $error("direct bank wrong");

  a_ind_bank: assert property (@(posedge clock) disable iff (rst) // RULE11
    (operand == 7'h00 && indirect_pointer[6:0] >= 7'h20 &&
     indirect_pointer[6:0] < 7'h70) |->
      dif.phys_addr == {status[7], indirect_pointer})
    else $error("indirect address wrong");

  a_fast_shared: assert property (@(posedge clock) disable iff (rst) // RULE13
    (operand >= 7'h70) |-> dif.phys_addr[8:7] == 2'b00)
    else $error("fast region not shared");

  a_sfr_flag: assert property (@(posedge clock) disable iff (rst) // RULE2
    (op == BDM_OP_LOAD_ACC && operand >= 7'h20 && operand < 7'h70)
      |=> !sfr_access)
    else $error("gpr flagged as sfr");

  // window offset excluded: it redirects through the pointer
  a_sfr_hit: assert property (@(posedge clock) disable iff (rst) // RULE2
    (op == BDM_OP_LOAD_ACC && operand <= OFF_SFR_LAST &&
     operand != OFF_INDIRECT_WINDOW && status[6:5] != 2'b11)
      |=> sfr_access)
    else $error("sfr access not flagged");

  a_ro_keep: assert property (@(posedge clock) disable iff (rst) // RULE3
    (op == BDM_OP_STORE_ACC && dif.is_ro) |=>
      $stable(mem_reg[ADDR_RO_TABLE_HIGH]))
    else $error("read-only location written");

  a_ro_read: assert property (@(posedge clock) disable iff (rst) // RULE3
    (op == BDM_OP_LOAD_ACC && dif.is_ro) |=>
      accumulator == $past(table_high_in))
    else $error("read-only location not read");

  a_gpr_store: assert property (@(posedge clock) disable iff (rst) // RULE8
    (op == BDM_OP_STORE_ACC && operand >= 7'h20 && operand < 7'h70) |=>
      mem_reg[$past(dif.phys_addr)] == $past(accumulator))
    else $error("direct store lost");

endmodule // bdm_top

// ==== test/bdm_core_model.sv ====
`timescale 1ns/10ps
module bdm_core_model
  import bdm_pkg::*;
(
  // clock
  input  wire logic        clock,
  // instruction stream
  output bdm_pkg::bdm_op_e op,
  output logic [6:0]       operand,
  output logic [7:0]       immediate,
  // alu flag updates, idle until alu_flags drives them
  output logic             flags_we,
  output logic [4:0]       flags_in
);
  // -------------------------------------------------------------
  // idle instruction at time zero
  // -------------------------------------------------------------
  initial begin
    op = BDM_OP_NONE;
    operand = 7'h00;
    immediate = 8'h00;
    flags_we = 1'b0;
    flags_in = 5'h00;
  end

  // one instruction, then idle; returns once its edge has landed
  task automatic issue(input bdm_op_e o, input logic [6:0] off,
                       input logic [7:0] imm);
    @(posedge clock);
    op <= o;
    operand <= off;
    immediate <= imm;
    @(posedge clock);
    op <= BDM_OP_NONE;
    #1;
  endtask

  // one alu flag update, then idle
  task automatic alu_flags(input logic [4:0] f);
    @(posedge clock);
    flags_we <= 1'b1;
    flags_in <= f;
    @(posedge clock);
    flags_we <= 1'b0;
    #1;
  endtask
endmodule // bdm_core_model

// ==== test/bdm_top_tb.sv ====
`timescale 1ns/10ps
module bdm_top_tb
  import bdm_pkg::*;
;
  logic       clock;
  logic       rst;
  bdm_op_e    op;
  logic [6:0] operand;
  logic [7:0] immediate;
  logic       flags_we;
  logic [4:0] flags_in;
  logic [7:0] table_high_in;
  logic [7:0] accumulator;
  logic [7:0] status;
  logic [7:0] indirect_pointer;
  logic [7:0] program_counter_low;
  logic [7:0] program_counter_high_latch;
  logic [7:0] interrupt_control;
  logic       sfr_access;
  int         num_errors;
  int         total_checks;

  bdm_core_model bdm_core_model_inst (.clock(clock), .op(op),
    .operand(operand), .immediate(immediate), .flags_we(flags_we),
    .flags_in(flags_in));

  bdm_top bdm_top_inst (.clock(clock), .rst(rst), .op(op),
    .operand(operand), .immediate(immediate), .flags_we(flags_we),
    .flags_in(flags_in), .table_high_in(table_high_in),
    .accumulator(accumulator), .status(status),
    .indirect_pointer(indirect_pointer),
    .program_counter_low(program_counter_low),
    .program_counter_high_latch(program_counter_high_latch),
    .interrupt_control(interrupt_control), .sfr_access(sfr_access));

  // -------------------------------------------------------------
  // clock and access tasks
  // -------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic imm(input logic [7:0] v);
    bdm_core_model_inst.issue(BDM_OP_LOAD_IMM, 7'h00, v);
  endtask
  task automatic st(input logic [6:0] off);
    bdm_core_model_inst.issue(BDM_OP_STORE_ACC, off, 8'h00);
  endtask
  task automatic ld(input logic [6:0] off);
    bdm_core_model_inst.issue(BDM_OP_LOAD_ACC, off, 8'h00);
  endtask
  // status store; bits 4:3 are kept by the device
  task automatic sv(input logic [7:0] v);
    imm(v);
    st(OFF_STATUS);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic done(input string name);
    $display("test %s finished at %0t", name, $time);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    give_verdict();
  end

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    rst = 1'b1;
    table_high_in = 8'h3c;
    num_errors = 0;
    total_checks = 0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk(status, STATUS_RST);
    chk(accumulator, 8'h00);
    chk(program_counter_low, 8'h00);
    chk(indirect_pointer, 8'h00);
    chk(program_counter_high_latch, 8'h00);
    chk(interrupt_control, 8'h00);
    done("reset");
    imm(8'h5a);
    chk(accumulator, 8'h5a);
    st(7'h30);
    imm(8'h00);
    ld(7'h30);
    chk(accumulator, 8'h5a);
    done("direct");
    // distinct byte per bank, sfr decode per bank
    for (int b = 0; b < 4; b++) begin
      sv({1'b0, 2'(b), 5'h00});
      chk({5'h00, status[7:5]}, 8'(b));
      imm(8'h40 + 8'(b));
      st(7'h6f);
      ld(7'h1f);
      chk_bit(sfr_access, b != 3);
      ld(7'h0b);
      chk_bit(sfr_access, 1'b1);
      ld(7'h20);
      chk_bit(sfr_access, 1'b0);
    end
    for (int b = 0; b < 4; b++) begin
      sv({1'b0, 2'(b), 5'h00});
      ld(7'h6f);
      chk(accumulator, 8'h40 + 8'(b));
    end
    done("banks");
    imm(8'h2c);
    st(OFF_PC_HIGH_LATCH);
    st(OFF_INT_CONTROL);
    st(7'h75);
    chk(program_counter_high_latch, 8'h2c);
    chk(interrupt_control, 8'h2c);
    sv(8'h20);
    ld(OFF_PC_HIGH_LATCH);
    chk(accumulator, 8'h2c);
    ld(7'h75);
    chk(accumulator, 8'h2c);
    done("mirrors");
    imm(8'h45);
    st(OFF_INDIRECT_PTR);
    imm(8'h77);
    st(OFF_INDIRECT_WINDOW);
    sv(8'h80);
    imm(8'h88);
    st(OFF_INDIRECT_WINDOW);
    ld(7'h45);
    chk(accumulator, 8'h77);
    sv(8'h40);
    ld(7'h45);
    chk(accumulator, 8'h88);
    ld(OFF_INDIRECT_WINDOW);
    chk(accumulator, 8'h77);
    done("indirect");
    imm(8'h00);
    st(OFF_INDIRECT_PTR);
    imm(8'h99);
    st(OFF_INDIRECT_WINDOW);
    chk(indirect_pointer, 8'h00);
    chk(status, 8'h58);
    ld(OFF_INDIRECT_WINDOW);
    chk(accumulator, WINDOW_SELF_READ);
    imm(8'h80);
    st(OFF_INDIRECT_PTR);
    ld(OFF_INDIRECT_WINDOW);
    chk(accumulator, 8'h00);
    done("window self");
    sv(8'h20);
    imm(8'ha5);
    st(7'h14);
    ld(7'h14);
    chk(accumulator, 8'h3c);
    @(posedge clock);
    table_high_in <= 8'hc3;
    ld(7'h14);
    chk(accumulator, 8'hc3);
    done("read only");
    // core registers written in bank 1, read back from bank 2
    imm(8'h11);
    st(OFF_PC_LOW);
    chk(program_counter_low, 8'h11);
    bdm_core_model_inst.alu_flags(5'h07);
    chk(status, 8'h27);
    sv(8'h47);
    ld(OFF_STATUS);
    chk(accumulator, 8'h47);
    ld(OFF_PC_LOW);
    chk(accumulator, 8'h11);
    done("core registers");
    give_verdict();
  end
endmodule // bdm_top_tb
